// >>> rtl/mfpc_pin_config.sv
// Purpose: multifunction pin configuration with Avalon-MM register port
// Assumes: single clock core_clk, mic clock and data lines arrive asynchronously
// Notes: pin outputs are registered, so role changes take effect one cycle later
//
// Contract
// - edge bit 0 odd falling, 1 swaps
// - edge bit 7 controls line one
// - edge bit 6 controls line two
// - edge bit 5 controls line three
// - edge bit 4 line four; bits 3-0 zero
// - bidir codes 0-4 select output roles
// - bidir codes 8-11 select input roles
// - bidir codes 12-15 select density data inputs
// - bidir drive field selects output style
// - bidir serial audio output ignores drive style
// - output pin codes 0-4 select roles
// - output drive bit: 0 hiz, 1 push-pull
`timescale 1ns/1ps
module mfpc_pin_config
  import mfpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // internal sources routed to the pins
  input wire logic general_output_val,
  input wire logic irq_level,
  input wire logic secondary_serial_audio_out,
  input wire logic density_mic_clock,
  // bidirectional pin
  input wire logic bidir_pin_in,
  output logic bidir_pin_out,
  output logic bidir_pin_oe,
  output logic bidir_pin_weak_oe,
  // output-only pin
  output logic out_pin_out,
  output logic out_pin_oe,
  // dedicated density data pins, one per line
  input wire logic [3:0] density_data_pins,
  // role results of the bidirectional pin
  output logic mic_bias_on_control,
  output logic general_input,
  output logic ctrl_clock_in,
  output logic daisy_chain_audio_in,
  // captured channel bits, channel 1 at index 0
  output logic [7:0] channel_bits,
  output logic [3:0] pair_valid
);

  // ==========================================================
  // registers
  logic [7:0] edge_q;
  logic [7:0] bidir_q;
  logic [7:0] out1_q;
  mfpc_bus_e bus_q;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;
  logic wait_q;

  logic [3:0] bidir_func;
  logic [2:0] bidir_drv;
  logic [3:0] out_func;
  logic [3:0] line_edge_sel;
  logic line_one_edge_sel;
  logic line_two_edge_sel;
  logic line_three_edge_sel;
  logic line_four_edge_sel;

  assign bidir_func = bidir_q[MFPC_FUNC_LSB +: 4];
  assign bidir_drv = bidir_q[MFPC_DRV_LSB +: 3];
  assign out_func = out1_q[MFPC_FUNC_LSB +: 4];
  assign line_one_edge_sel = edge_q[MFPC_EDGE_LINE1_BIT];
  assign line_two_edge_sel = edge_q[MFPC_EDGE_LINE2_BIT];
  assign line_three_edge_sel = edge_q[MFPC_EDGE_LINE3_BIT];
  assign line_four_edge_sel = edge_q[MFPC_EDGE_LINE4_BIT];
  assign line_edge_sel = {line_four_edge_sel, line_three_edge_sel,
                          line_two_edge_sel, line_one_edge_sel};

  // ==========================================================
  // bus slave: one wait cycle, answer on the second edge
  logic hit_edge;
  logic hit_bidir;
  logic hit_out1;
  logic hit_any;
  logic req;

  assign hit_edge = (avs_address == MFPC_ADDR_EDGE);
  assign hit_bidir = (avs_address == MFPC_ADDR_BIDIR);
  assign hit_out1 = (avs_address == MFPC_ADDR_OUT1);
  assign hit_any = hit_edge || hit_bidir || hit_out1;
  assign req = avs_read || avs_write;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_q <= MFPC_BUS_IDLE;
    end else begin
      case (bus_q)
        MFPC_BUS_IDLE: begin
          if (req) begin
            bus_q <= MFPC_BUS_ACK;
          end
        end
        MFPC_BUS_ACK: bus_q <= MFPC_BUS_DONE;
        MFPC_BUS_DONE: bus_q <= MFPC_BUS_IDLE;
        default: bus_q <= MFPC_BUS_IDLE;
      endcase
    end
  end

  // waitrequest drops for exactly the ack cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(bus_q == MFPC_BUS_IDLE && req);
    end
  end

  logic do_write;
  assign do_write = (bus_q == MFPC_BUS_ACK) && avs_write && avs_byteenable[0];

  // reserved bits are masked so they always read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      edge_q <= MFPC_RST_EDGE;
    end else if (do_write && hit_edge) begin
      edge_q <= avs_writedata[7:0] & MFPC_MASK_EDGE;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bidir_q <= MFPC_RST_BIDIR;
    end else if (do_write && hit_bidir) begin
      bidir_q <= avs_writedata[7:0] & MFPC_MASK_BIDIR;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out1_q <= MFPC_RST_OUT1;
    end else if (do_write && hit_out1) begin
      out1_q <= avs_writedata[7:0] & MFPC_MASK_OUT1;
    end
  end

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hit_edge) begin
      rd_mux = edge_q;
    end else if (hit_bidir) begin
      rd_mux = bidir_q;
    end else if (hit_out1) begin
      rd_mux = out1_q;
    end
  end

  // unmapped: reads zero, response slave error
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
      resp_q <= 2'h0;
    end else if (bus_q == MFPC_BUS_IDLE && req) begin
      rdata_q <= {24'h00_0000, rd_mux};
      resp_q <= hit_any ? 2'h0 : 2'h2;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign avs_response = resp_q;

  // ==========================================================
  // synchronisers for pins and the external mic clock
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic mclk_prev_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {bidir_pin_in, density_mic_clock, density_data_pins};
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mclk_prev_q <= 1'b0;
    end else begin
      mclk_prev_q <= sync2_q[4];
    end
  end

  logic pin_s;
  logic mclk_s;
  logic clk_rise;
  logic clk_fall;
  assign pin_s = sync2_q[5];
  assign mclk_s = sync2_q[4];
  assign clk_rise = mclk_s && !mclk_prev_q;
  assign clk_fall = !mclk_s && mclk_prev_q;

  // ==========================================================
  // density data lines; the bidir pin can replace one of them
  logic [3:0] line_data;
  always_comb begin
    line_data = sync2_q[3:0];
    case (bidir_func)
      MFPC_FN_PDM_L1: line_data[0] = pin_s;
      MFPC_FN_PDM_L2: line_data[1] = pin_s;
      MFPC_FN_PDM_L3: line_data[2] = pin_s;
      MFPC_FN_PDM_L4: line_data[3] = pin_s;
      default: line_data = sync2_q[3:0];
    endcase
  end

  mfpc_pair_s pairs [MFPC_LINES];

  genvar gi;
  generate
    for (gi = 0; gi < MFPC_LINES; gi++) begin : g_line
      mfpc_line_capture u_cap (
        .core_clk(core_clk),
        .rst(rst),
        .clk_rise(clk_rise),
        .clk_fall(clk_fall),
        .data_in(line_data[gi]),
        .edge_sel(line_edge_sel[gi]),
        .pair(pairs[gi])
      );
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      channel_bits <= 8'h00;
      pair_valid <= 4'h0;
    end else begin
      for (int i = 0; i < MFPC_LINES; i++) begin
        channel_bits[2*i] <= pairs[i].odd_bit;
        channel_bits[2*i+1] <= pairs[i].even_bit;
        pair_valid[i] <= pairs[i].valid;
      end
    end
  end

  // ==========================================================
  // input roles of the bidir pin
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mic_bias_on_control <= 1'b0;
      general_input <= 1'b0;
      ctrl_clock_in <= 1'b0;
      daisy_chain_audio_in <= 1'b0;
    end else begin
      mic_bias_on_control <= (bidir_func == MFPC_FN_MICBIAS) && pin_s;
      general_input <= (bidir_func == MFPC_FN_GEN_IN) && pin_s;
      ctrl_clock_in <= (bidir_func == MFPC_FN_CTRL_CLK) && pin_s;
      daisy_chain_audio_in <= (bidir_func == MFPC_FN_DAISY_IN) && pin_s;
    end
  end

  // ==========================================================
  // output roles: source level and whether a role is active
  function automatic logic [1:0] role_src(input logic [3:0] fn);
    logic [1:0] r;
    r = 2'b00;
    case (fn)
      MFPC_FN_GEN_OUT: r = {1'b1, general_output_val};
      MFPC_FN_IRQ_OUT: r = {1'b1, irq_level};
      MFPC_FN_SER_OUT: r = {1'b1, secondary_serial_audio_out};
      MFPC_FN_MIC_CLK: r = {1'b1, density_mic_clock};
      default: r = 2'b00; // disabled, inputs and reserved: no output
    endcase
    return r;
  endfunction : role_src

  logic [1:0] bidir_role;
  logic [1:0] out_role;
  // a process, not assign: source levels read inside the function must wake it
  always_comb begin
    bidir_role = role_src(bidir_func);
    out_role = role_src(out_func);
  end

  // drive style maps the level onto strong and weak enables
  mfpc_pin_s bidir_pin_d;
  always_comb begin
    bidir_pin_d = '{out: 1'b0, oe: 1'b0, weak_oe: 1'b0};
    if (bidir_role[1]) begin
      if (bidir_func == MFPC_FN_SER_OUT) begin
        bidir_pin_d = '{out: bidir_role[0], oe: 1'b1, weak_oe: 1'b0};
      end else begin
        case (bidir_drv)
          MFPC_DRV_HIZ: bidir_pin_d.out = 1'b0;
          MFPC_DRV_BOTH: bidir_pin_d = '{out: bidir_role[0], oe: 1'b1, weak_oe: 1'b0};
          MFPC_DRV_LOW_WEAKHI: bidir_pin_d = '{out: bidir_role[0],
                                               oe: !bidir_role[0], weak_oe: bidir_role[0]};
          MFPC_DRV_LOW_HIZ: bidir_pin_d = '{out: 1'b0, oe: !bidir_role[0], weak_oe: 1'b0};
          MFPC_DRV_WEAKLO_HIGH: bidir_pin_d = '{out: bidir_role[0],
                                                oe: bidir_role[0], weak_oe: !bidir_role[0]};
          MFPC_DRV_HIZ_HIGH: bidir_pin_d = '{out: 1'b1, oe: bidir_role[0], weak_oe: 1'b0};
          default: bidir_pin_d.out = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bidir_pin_out <= 1'b0;
      bidir_pin_oe <= 1'b0;
      bidir_pin_weak_oe <= 1'b0;
    end else begin
      bidir_pin_out <= bidir_pin_d.out;
      bidir_pin_oe <= bidir_pin_d.oe;
      bidir_pin_weak_oe <= bidir_pin_d.weak_oe;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_pin_out <= 1'b0;
      out_pin_oe <= 1'b0;
    end else begin
      out_pin_out <= out_role[1] && out_role[0];
      out_pin_oe <= out_role[1] && out1_q[MFPC_OUT_DRV_BIT];
    end
  end

endmodule : mfpc_pin_config

// >>> rtl/mfpc_pkg.sv
// Purpose: shared constants and types for the multifunction pin configuration block
// Assumes: 32-bit Avalon-MM register port, byte-index offsets scaled by four
// Notes: function and drive codes follow the register field encodings
package mfpc_pkg;

  // ==========================================================
  // register map (index; byte address is four times the index)
  localparam logic [7:0] MFPC_IDX_EDGE = 8'h20;
  localparam logic [7:0] MFPC_IDX_BIDIR = 8'h21;
  localparam logic [7:0] MFPC_IDX_OUT1 = 8'h22;
  localparam int MFPC_ADDR_W = 10;
  localparam logic [9:0] MFPC_ADDR_EDGE = {MFPC_IDX_EDGE, 2'b00};
  localparam logic [9:0] MFPC_ADDR_BIDIR = {MFPC_IDX_BIDIR, 2'b00};
  localparam logic [9:0] MFPC_ADDR_OUT1 = {MFPC_IDX_OUT1, 2'b00};

  // ==========================================================
  // reset values
  localparam logic [7:0] MFPC_RST_EDGE = 8'h00;
  localparam logic [7:0] MFPC_RST_BIDIR = 8'h22;
  localparam logic [7:0] MFPC_RST_OUT1 = 8'h00;

  // ==========================================================
  // field positions and writable masks
  localparam int MFPC_EDGE_LINE1_BIT = 7;
  localparam int MFPC_EDGE_LINE2_BIT = 6;
  localparam int MFPC_EDGE_LINE3_BIT = 5;
  localparam int MFPC_EDGE_LINE4_BIT = 4;
  localparam logic [7:0] MFPC_MASK_EDGE = 8'hf0;
  localparam logic [7:0] MFPC_MASK_BIDIR = 8'hf7;
  localparam logic [7:0] MFPC_MASK_OUT1 = 8'hf1;
  localparam int MFPC_FUNC_LSB = 4;
  localparam int MFPC_DRV_LSB = 0;
  localparam int MFPC_OUT_DRV_BIT = 0;

  // ==========================================================
  // function codes
  localparam logic [3:0] MFPC_FN_DISABLED = 4'h0;
  localparam logic [3:0] MFPC_FN_GEN_OUT = 4'h1;
  localparam logic [3:0] MFPC_FN_IRQ_OUT = 4'h2;
  localparam logic [3:0] MFPC_FN_SER_OUT = 4'h3;
  localparam logic [3:0] MFPC_FN_MIC_CLK = 4'h4;
  localparam logic [3:0] MFPC_FN_MICBIAS = 4'h8;
  localparam logic [3:0] MFPC_FN_GEN_IN = 4'h9;
  localparam logic [3:0] MFPC_FN_CTRL_CLK = 4'ha;
  localparam logic [3:0] MFPC_FN_DAISY_IN = 4'hb;
  localparam logic [3:0] MFPC_FN_PDM_L1 = 4'hc;
  localparam logic [3:0] MFPC_FN_PDM_L2 = 4'hd;
  localparam logic [3:0] MFPC_FN_PDM_L3 = 4'he;
  localparam logic [3:0] MFPC_FN_PDM_L4 = 4'hf;

  // ==========================================================
  // drive style codes
  localparam logic [2:0] MFPC_DRV_HIZ = 3'h0;
  localparam logic [2:0] MFPC_DRV_BOTH = 3'h1;
  localparam logic [2:0] MFPC_DRV_LOW_WEAKHI = 3'h2;
  localparam logic [2:0] MFPC_DRV_LOW_HIZ = 3'h3;
  localparam logic [2:0] MFPC_DRV_WEAKLO_HIGH = 3'h4;
  localparam logic [2:0] MFPC_DRV_HIZ_HIGH = 3'h5;

  localparam int MFPC_LINES = 4;

  // pin drive bundle: strong drive enable and weak pull enable with level
  typedef struct packed {
    logic out;
    logic oe;
    logic weak_oe;
  } mfpc_pin_s;

  // per-line captured channel pair
  typedef struct packed {
    logic odd_bit;
    logic even_bit;
    logic valid;
  } mfpc_pair_s;

  typedef enum logic [2:0] {
    MFPC_BUS_IDLE = 3'b001,
    MFPC_BUS_ACK = 3'b010,
    MFPC_BUS_DONE = 3'b100
  } mfpc_bus_e;

endpackage : mfpc_pkg

// >>> rtl/mfpc_line_capture.sv
// Purpose: capture one pulse-density data line into its odd and even channel bits
// Assumes: data and mic clock already synchronised into core_clk
// Notes: mic clock must run well below core_clk/4 for edge detection
`timescale 1ns/1ps
module mfpc_line_capture
  import mfpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_rise,
  input wire logic clk_fall,
  input wire logic data_in,
  input wire logic edge_sel,
  output mfpc_pair_s pair
);

  logic odd_q;
  logic even_q;
  logic valid_q;

  // ==========================================================
  // sel 0: odd on falling, even on rising; sel 1 swaps
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      odd_q <= 1'b0;
      even_q <= 1'b0;
    end else begin
      if ((clk_fall && !edge_sel) || (clk_rise && edge_sel)) begin
        odd_q <= data_in;
      end
      if ((clk_rise && !edge_sel) || (clk_fall && edge_sel)) begin
        even_q <= data_in;
      end
    end
  end

  // pair is complete once per clock period, at the later of the two edges
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= edge_sel ? clk_rise : clk_fall;
    end
  end

  assign pair = '{odd_bit: odd_q, even_bit: even_q, valid: valid_q};

endmodule : mfpc_line_capture

// >>> dv/mfpc_mic_model.sv
// Purpose: behavioural set of density microphones on four data lines
// Assumes: HALF core cycles per clock phase
// Notes: data flips mid-phase so both capture edges see settled bits
`timescale 1ns/1ps
module mfpc_mic_model #(
  parameter int HALF = 8
) (
  input wire logic core_clk,
  input wire logic run,
  input wire logic [3:0] odd_v,
  input wire logic [3:0] even_v,
  output logic mic_clk,
  output logic [3:0] data
);
  int cnt = 0;
  logic idle_t = 1'h0;
  logic clk_q = 1'h0;
  assign mic_clk = clk_q;
  // ==========================================
  // clock stands still outside frames
  always @(posedge core_clk) begin
    idle_t <= ~idle_t;
    if (!run) begin
      clk_q <= 1'h0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      clk_q <= ~clk_q;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // odd bit settled around the falling edge, even around the rising edge
  always_comb begin
    if (!run) data = {4{idle_t}};
    else data = (mic_clk == (cnt >= HALF / 2)) ? odd_v : even_v;
  end
endmodule : mfpc_mic_model

// >>> dv/mfpc_pin_config_properties.sv
// Purpose: port-level checks of the pin configuration block
// Assumes: mic clock phases of at least six core cycles
// Notes: bound onto every instance of the block
`timescale 1ns/1ps
module mfpc_pin_config_properties
  import mfpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic general_output_val,
  input wire logic irq_level,
  input wire logic secondary_serial_audio_out,
  input wire logic density_mic_clock,
  input wire logic bidir_pin_oe,
  input wire logic bidir_pin_weak_oe,
  input wire logic out_pin_out,
  input wire logic out_pin_oe,
  input wire logic mic_bias_on_control,
  input wire logic general_input,
  input wire logic ctrl_clock_in,
  input wire logic daisy_chain_audio_in,
  input wire logic [3:0] pair_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic clk_seen_q;
  logic [7:0] since_q;
  logic [3:0] out_fn_q;
  logic out_exp_q;
  // ==========================================
  // output pin role tracked from bus writes; level expected one cycle on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_fn_q <= MFPC_RST_OUT1[7:4];
      out_exp_q <= 1'h0;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == MFPC_ADDR_OUT1) begin
        out_fn_q <= avs_writedata[7:4];
      end
      case (out_fn_q)
        MFPC_FN_GEN_OUT: out_exp_q <= general_output_val;
        MFPC_FN_IRQ_OUT: out_exp_q <= irq_level;
        MFPC_FN_SER_OUT: out_exp_q <= secondary_serial_audio_out;
        default: out_exp_q <= density_mic_clock;
      endcase
    end
  end
  // ==========================================
  // cycles since the mic clock last changed
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_seen_q <= 1'h0;
      since_q <= 8'hff;
    end else begin
      clk_seen_q <= density_mic_clock;
      if (clk_seen_q != density_mic_clock) since_q <= 8'h00;
      else if (since_q != 8'hff) since_q <= since_q + 8'h01;
    end
  end
  // ==========================================
  // assertions
  a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_req_answered: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_no_stray_ack: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  a_edge_rsvd_zero: assert property (
    avs_read && !avs_waitrequest && avs_address == MFPC_ADDR_EDGE
    |-> avs_readdata[3:0] == 4'h0 && avs_readdata[31:8] == 24'h0)
    else $error("edge register reserved bits not zero");
  a_valid_one_pulse: assert property (|pair_valid |=> pair_valid == 4'h0)
    else $error("pair valid longer than one cycle");
  a_valid_after_edge: assert property (|pair_valid |-> since_q < 8'h06)
    else $error("pair valid not tied to a mic clock edge");
  a_roles_onehot: assert property (
    $onehot0({mic_bias_on_control, general_input, ctrl_clock_in, daisy_chain_audio_in}))
    else $error("more than one input role active");
  a_input_undriven: assert property (
    (mic_bias_on_control || general_input || ctrl_clock_in || daisy_chain_audio_in)
    |-> !bidir_pin_oe && !bidir_pin_weak_oe)
    else $error("bidir pin driven while used as input");
  a_drive_exclusive: assert property (!(bidir_pin_oe && bidir_pin_weak_oe))
    else $error("strong and weak drive together");
  a_out_source: assert property (out_pin_oe |-> out_pin_out == out_exp_q)
    else $error("output pin level not from its selected source");
  c_line_four: cover property (pair_valid[3]);
  c_weak_drive: cover property (bidir_pin_weak_oe);
  c_out_high: cover property (out_pin_oe && out_pin_out);
  c_gen_input: cover property (general_input);
endmodule : mfpc_pin_config_properties

bind mfpc_pin_config mfpc_pin_config_properties mfpc_pin_config_properties_inst (
  .core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
  .avs_waitrequest,
  .general_output_val, .irq_level, .secondary_serial_audio_out, .density_mic_clock,
  .bidir_pin_oe, .bidir_pin_weak_oe, .out_pin_out, .out_pin_oe, .mic_bias_on_control,
  .general_input, .ctrl_clock_in, .daisy_chain_audio_in, .pair_valid
);

// >>> dv/mfpc_pin_config_tb.sv
// Purpose: self-checking bench for the pin configuration block
// Assumes: mic model at eight core cycles per phase
// Notes: expectations rebuilt from the field encodings
`timescale 1ns/1ps
module mfpc_pin_config_tb import mfpc_pkg::*; ;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic [9:0] adr = 10'h000;
  logic rd = 1'h0;
  logic wr_en = 1'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wait_r;
  logic [1:0] resp;
  logic gv = 1'h1;
  logic irq_v = 1'h0;
  logic ssao = 1'h1;
  logic pin_in = 1'h0;
  logic run = 1'h0;
  logic [3:0] odd_v = 4'h6;
  logic [3:0] even_v = 4'h9;
  logic mclk;
  logic [3:0] dpins;
  logic b_out;
  logic b_oe;
  logic b_weak;
  logic o_out;
  logic o_oe;
  logic [3:0] roles;
  logic [7:0] ch;
  logic [3:0] pv;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;

  always #10 core_clk = ~core_clk;

  mfpc_mic_model mfpc_mic_model_inst (.core_clk(core_clk), .run(run), .odd_v(odd_v),
    .even_v(even_v), .mic_clk(mclk), .data(dpins));
  mfpc_pin_config mfpc_pin_config_inst (.core_clk(core_clk), .rst(rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr_en), .avs_writedata(wdat), .avs_byteenable(4'hf),
    .avs_readdata(rdat), .avs_waitrequest(wait_r), .avs_response(resp),
    .general_output_val(gv), .irq_level(irq_v), .secondary_serial_audio_out(ssao),
    .density_mic_clock(mclk), .bidir_pin_in(pin_in), .bidir_pin_out(b_out),
    .bidir_pin_oe(b_oe), .bidir_pin_weak_oe(b_weak), .out_pin_out(o_out), .out_pin_oe(o_oe),
    .density_data_pins(dpins), .mic_bias_on_control(roles[3]), .general_input(roles[2]),
    .ctrl_clock_in(roles[1]), .daisy_chain_audio_in(roles[0]), .channel_bits(ch),
    .pair_valid(pv));

  // ==========================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // holds the request until waitrequest is sampled low, then one idle edge
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    int n;
    n = 0;
    adr <= a;
    wdat <= {24'h000000, d};
    rd <= !w;
    wr_en <= w;
    do begin
      @(posedge core_clk);
      n++;
    end while (wait_r !== 1'h0 && n < 50);
    chk("bus answer", 32'h0, {31'h0, wait_r});
    q = rdat;
    r = resp;
    rd <= 1'h0;
    wr_en <= 1'h0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'h1, a, d, q, r);
  endtask : wr

  task automatic wait_valid(input int k);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pv[k] !== 1'h1 && n < 100);
    chk("pair valid", 32'h1, {31'h0, pv[k]});
  endtask : wait_valid

  function automatic logic src(input logic [3:0] c);
    case (c)
      4'h1: return gv;
      4'h2: return irq_v;
      4'h3: return ssao;
      default: return mclk;
    endcase
  endfunction : src

  // {strong, weak} for a drive style and output level
  function automatic logic [1:0] sty(input int s, input logic v);
    case (s)
      1: return 2'h2;
      2: return v ? 2'h1 : 2'h2;
      3: return v ? 2'h0 : 2'h2;
      4: return v ? 2'h2 : 2'h1;
      5: return v ? 2'h2 : 2'h0;
      default: return 2'h0;
    endcase
  endfunction : sty

  // ==========================================
  // scenarios
  task automatic t_regs();
    logic [9:0] ad [3] = '{MFPC_ADDR_EDGE, MFPC_ADDR_BIDIR, MFPC_ADDR_OUT1};
    logic [7:0] rv [3] = '{8'h00, 8'h22, 8'h00};
    logic [7:0] mk [3] = '{8'hf0, 8'hf7, 8'hf1};
    logic [31:0] q;
    logic [1:0] r;
    for (int i = 0; i < 3; i++) begin
      bus(1'h0, ad[i], 8'h00, q, r);
      chk("reset value", {24'h0, rv[i]}, q);
      bus(1'h1, ad[i], 8'hff, q, r);
      bus(1'h0, ad[i], 8'h00, q, r);
      chk("masked readback", {24'h0, mk[i]}, q);
    end
    bus(1'h1, 10'h08c, 8'h5a, q, r);
    chk("unmapped response", 32'h2, {30'h0, r});
    bus(1'h0, 10'h08c, 8'h00, q, r);
    chk("unmapped read", 32'h0, q);
  endtask : t_regs

  task automatic t_edges();
    logic [7:0] ev [4] = '{8'h00, 8'ha0, 8'h50, 8'hf0};
    logic [7:0] e;
    wr(MFPC_ADDR_BIDIR, MFPC_RST_BIDIR);
    run <= 1'h1;
    foreach (ev[i]) begin
      wr(MFPC_ADDR_EDGE, ev[i]);
      for (int k = 0; k < 4; k++) begin
        e[2 * k] = ev[i][7 - k] ? even_v[k] : odd_v[k];
        e[2 * k + 1] = ev[i][7 - k] ? odd_v[k] : even_v[k];
      end
      wait_valid(0);
      wait_valid(0);
      chk("channel bits", {24'h0, e}, {24'h0, ch});
    end
    run <= 1'h0;
  endtask : t_edges

  task automatic t_out_pin();
    logic e;
    for (int c = 0; c < 16; c++) begin
      for (int d = 0; d < 2; d++) begin
        wr(MFPC_ADDR_OUT1, {c[3:0], 3'h0, d[0]});
        @(posedge core_clk);
        e = d[0] && c >= 1 && c <= 4;
        chk("out pin enable", {31'h0, e}, {31'h0, o_oe});
        if (e) chk("out pin level", {31'h0, src(c[3:0])}, {31'h0, o_out});
      end
    end
  endtask : t_out_pin

  task automatic t_bidir_out();
    for (int c = 0; c < 8; c++) begin
      wr(MFPC_ADDR_BIDIR, {c[3:0], 4'h1});
      @(posedge core_clk);
      chk("bidir role", {30'h0, c >= 1 && c <= 4, 1'h0}, {30'h0, b_oe, b_weak});
    end
    wr(MFPC_ADDR_BIDIR, {MFPC_FN_SER_OUT, 4'h0});
    @(posedge core_clk);
    chk("serial out drive", {29'h0, 2'h2, ssao}, {29'h0, b_oe, b_weak, b_out});
    for (int s = 0; s < 8; s++) begin
      for (int v = 0; v < 2; v++) begin
        gv <= v[0];
        wr(MFPC_ADDR_BIDIR, {4'h1, 1'h0, s[2:0]});
        @(posedge core_clk);
        chk("drive style", {30'h0, sty(s, v[0])}, {30'h0, b_oe, b_weak});
        if (sty(s, v[0]) != 2'h0) chk("drive level", {31'h0, v[0]}, {31'h0, b_out});
      end
    end
  endtask : t_bidir_out

  task automatic t_bidir_in();
    pin_in <= 1'h1;
    for (int c = 8; c < 12; c++) begin
      wr(MFPC_ADDR_BIDIR, {c[3:0], 4'h0});
      @(posedge core_clk);
      chk("input role", {28'h0, 4'h8 >> (c - 8)}, {28'h0, roles});
    end
    odd_v <= 4'h0;
    even_v <= 4'h0;
    run <= 1'h1;
    for (int c = 12; c < 16; c++) begin
      wr(MFPC_ADDR_BIDIR, {c[3:0], 4'h0});
      wait_valid(c - 12);
      wait_valid(c - 12);
      chk("pin as data line", {24'h0, 8'h03 << (2 * (c - 12))}, {24'h0, ch});
    end
    run <= 1'h0;
  endtask : t_bidir_in

  // ==========================================
  // run control
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // whole run needs under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    t_regs();
    t_edges();
    t_out_pin();
    t_bidir_out();
    t_bidir_in();
    end_of_test();
  end
endmodule : mfpc_pin_config_tb
